// [rtl/cpei_pkg.sv]
package cpei_pkg;

    // ==========================================================
    // Bus geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // ==========================================================
    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_RTI_RATE = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_API_CTRL = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_API_RATE = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_WDOG = 4'h5;

    // ==========================================================
    // Control register fields
    localparam int CT_RTI_SEL = 0;
    localparam int CT_PSTOP = 1;
    localparam int CT_RTI_STOPRUN = 2;
    localparam int CT_OSC_EN = 3;
    localparam int CT_RTI_IE = 4;
    localparam int CT_LOCK_IE = 5;
    localparam int CT_OSC_IE = 6;
    localparam int CT_LV_IE = 7;
    localparam int CT_HT_IE = 8;
    localparam int CT_W = 9;

    // ==========================================================
    // Flag register fields, status bits above
    localparam int FL_RTI = 0;
    localparam int FL_LOCK = 1;
    localparam int FL_OSC = 2;
    localparam int FL_LV = 3;
    localparam int FL_HT = 4;
    localparam int FL_API = 5;
    localparam int FL_W = 6;
    localparam int ST_LOCK = 8;
    localparam int ST_OSCQ = 9;
    localparam int ST_LV = 10;
    localparam int ST_HT = 11;

    // ==========================================================
    // Periodic timer control fields
    localparam int AP_EN = 0;
    localparam int AP_CLKSEL = 1;
    localparam int AP_IE = 2;
    localparam int AP_PINEN = 3;
    localparam int AP_TRIM_LO = 4;
    localparam int TRIM_W = 6;

    // ==========================================================
    // Watchdog configuration fields
    localparam int WD_WIN = 0;
    localparam int WD_PER_LO = 1;
    localparam int WD_PER_W = 3;
    localparam int WD_LOCKED = 8;

    // ==========================================================
    // Input synchroniser lanes
    localparam int SY_IRC = 0;
    localparam int SY_OSC = 1;
    localparam int SY_ACLK = 2;
    localparam int SY_BUSRUN = 3;
    localparam int SY_STOP = 4;
    localparam int SY_LOCK = 5;
    localparam int SY_FSTOP = 6;
    localparam int SY_FPM = 7;
    localparam int SY_LVA = 8;
    localparam int SY_LVD = 9;
    localparam int SY_HTA = 10;
    localparam int SY_HTD = 11;
    localparam int SY_N = 12;

    // ==========================================================
    // Reset values
    localparam logic [DATA_W-1:0] RST_RATE = 16'h0000;

endpackage

// [rtl/cpei_top.sv]
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module cpei_top
    import cpei_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [DATA_W-1:0] regRdata,
    // Clock ticks from slow sources
    input wire logic internalRcClock,
    input wire logic oscillatorClock,
    input wire logic autonomousClock,
    input wire logic busClockRunning,
    // Mode and monitor inputs
    input wire logic stopMode,
    input wire logic fullStopMode,
    input wire logic fullPerformanceMode,
    input wire logic pllLock,
    input wire logic pllConfigChange,
    input wire logic lowVoltageBelowAssert,
    input wire logic lowVoltageAboveDeassert,
    input wire logic highTempAboveAssert,
    input wire logic highTempBelowDeassert,
    // Interrupt requests
    output logic rtiIrq,
    output logic lockIrq,
    output logic oscIrq,
    output logic lowVoltageIrq,
    output logic highTempIrq,
    output logic periodicIrq,
    // Waveform pin and trim
    output logic periodicWavePinOut,
    output logic periodicWavePinOe,
    output logic [TRIM_W-1:0] autonomousClockTrim,
    // Watchdog configuration
    output logic watchdogWindowEnable,
    output logic [WD_PER_W-1:0] watchdogPeriodSelect
);

    // ==========================================================
    // Input synchronisers
    // Three stages; a change is taken only when stages two and three agree
    logic [SY_N-1:0] syncIn;
    logic [SY_N-1:0] syncA;
    logic [SY_N-1:0] syncB;
    logic [SY_N-1:0] syncC;
    logic [SY_N-1:0] syncVal;
    logic [SY_N-1:0] syncPrev;
    wire [SY_N-1:0] syncRise;
    wire [SY_N-1:0] syncFall;

    assign syncIn = {highTempBelowDeassert, highTempAboveAssert, lowVoltageAboveDeassert,
                     lowVoltageBelowAssert, fullPerformanceMode, fullStopMode, pllLock,
                     stopMode, busClockRunning, autonomousClock, oscillatorClock,
                     internalRcClock};

    always_ff @(posedge clk) begin
        if (!resetn) begin
            syncA <= '0;
            syncB <= '0;
            syncC <= '0;
            syncVal <= '0;
            syncPrev <= '0;
        end else begin
            syncA <= syncIn;
            syncB <= syncA;
            syncC <= syncB;
            syncVal <= (syncB & syncC) | (syncVal & (syncB | syncC));
            syncPrev <= syncVal;
        end
    end

    assign syncRise = syncVal & ~syncPrev;
    assign syncFall = ~syncVal & syncPrev;

    // ==========================================================
    // Register bus decode
    wire wrCtrl = regWr && (regAddr == OFS_CTRL);
    wire wrFlags = regWr && (regAddr == OFS_FLAGS);
    wire wrRtiRate = regWr && (regAddr == OFS_RTI_RATE);
    wire wrApiCtrl = regWr && (regAddr == OFS_API_CTRL);
    wire wrApiRate = regWr && (regAddr == OFS_API_RATE);
    wire wrWdog = regWr && (regAddr == OFS_WDOG);

    logic [CT_W-1:0] ctrl;
    logic [DATA_W-1:0] rtiRate;
    logic [DATA_W-1:0] periodicRate;
    logic periodicTimerEnable;
    logic periodicClockSelect;
    logic periodicIrqEnable;
    logic periodicPinOutputEnable;
    logic watchdogLocked;
    logic [FL_W-1:0] flags;
    logic [FL_W-1:0] next_flags;
    logic [FL_W-1:0] flagSet;
    logic [FL_W-1:0] flagEnable;
    logic oscQualified;
    logic oscQualPrev;
    logic relockPending;
    logic lowVoltageStatus;
    logic lowVoltagePrev;
    logic highTempStatus;
    logic highTempPrev;
    logic [DATA_W-1:0] rtiCount;
    logic [DATA_W-1:0] apiCount;
    logic periodicWave;

    // ==========================================================
    // Control registers
    // Clock select and rate are frozen while the timer runs, so a
    // running period is never stretched by a stray write
    wire apiCfgOpen = !periodicTimerEnable;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrl <= '0;
            rtiRate <= RST_RATE;
            periodicRate <= RST_RATE;
            periodicTimerEnable <= 1'b0;
            periodicClockSelect <= 1'b0;
            periodicIrqEnable <= 1'b0;
            periodicPinOutputEnable <= 1'b0;
            autonomousClockTrim <= '0;
            watchdogLocked <= 1'b0;
            watchdogWindowEnable <= 1'b0;
            watchdogPeriodSelect <= '0;
        end else begin
            if (wrCtrl) begin
                ctrl <= regWdata[CT_W-1:0];
            end
            if (wrRtiRate) begin
                rtiRate <= regWdata;
            end
            if (wrApiCtrl) begin
                periodicTimerEnable <= regWdata[AP_EN];
                periodicIrqEnable <= regWdata[AP_IE];
                periodicPinOutputEnable <= regWdata[AP_PINEN];
                autonomousClockTrim <= regWdata[AP_TRIM_LO +: TRIM_W];
                if (apiCfgOpen) begin
                    periodicClockSelect <= regWdata[AP_CLKSEL];
                end
            end
            if (wrApiRate && apiCfgOpen) begin
                periodicRate <= regWdata;
            end
            // Write once; later writes cannot change the watchdog setup
            if (wrWdog && !watchdogLocked) begin
                watchdogLocked <= 1'b1;
                watchdogWindowEnable <= regWdata[WD_WIN];
                watchdogPeriodSelect <= regWdata[WD_PER_LO +: WD_PER_W];
            end
        end
    end

    wire rtiClockSelect = ctrl[CT_RTI_SEL];
    wire pseudoStopEnable = ctrl[CT_PSTOP];
    wire rtiStopRunEnable = ctrl[CT_RTI_STOPRUN];
    wire oscEnable = ctrl[CT_OSC_EN];

    // ==========================================================
    // Real-time interrupt counter
    wire rtiTick = rtiClockSelect ? syncRise[SY_OSC] : syncRise[SY_IRC];
    wire rtiRun = !syncVal[SY_STOP]
                  || (pseudoStopEnable && rtiClockSelect && rtiStopRunEnable);
    wire rtiExpire = rtiTick && rtiRun && (rtiCount == rtiRate) && !wrRtiRate;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rtiCount <= '0;
        end else if (wrRtiRate || rtiExpire) begin
            rtiCount <= '0;
        end else if (rtiTick && rtiRun) begin
            rtiCount <= rtiCount + 16'h0001;
        end
    end

    // ==========================================================
    // Oscillator qualification
    // A configuration change blocks qualification until lock is regained
    wire lockNow = syncVal[SY_LOCK];
    wire lockToggle = syncRise[SY_LOCK] || syncFall[SY_LOCK];
    wire next_relockPending = pllConfigChange || (relockPending && !syncRise[SY_LOCK]);
    wire next_oscQualified = oscEnable && lockNow && !syncVal[SY_FSTOP]
                             && !next_relockPending;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            relockPending <= 1'b0;
            oscQualified <= 1'b0;
            oscQualPrev <= 1'b0;
        end else begin
            relockPending <= next_relockPending;
            oscQualified <= next_oscQualified;
            oscQualPrev <= oscQualified;
        end
    end

    // ==========================================================
    // Supply and temperature status
    // Outside full performance mode the monitors are not trusted
    wire full_performance_mode = syncVal[SY_FPM];

    always_ff @(posedge clk) begin
        if (!resetn) begin
            lowVoltageStatus <= 1'b0;
            lowVoltagePrev <= 1'b0;
            highTempStatus <= 1'b0;
            highTempPrev <= 1'b0;
        end else begin
            if (full_performance_mode && syncVal[SY_LVA]) begin
                lowVoltageStatus <= 1'b1;
            end else if (full_performance_mode && syncVal[SY_LVD]) begin
                lowVoltageStatus <= 1'b0;
            end
            if (full_performance_mode && syncVal[SY_HTA]) begin
                highTempStatus <= 1'b1;
            end else if (full_performance_mode && syncVal[SY_HTD]) begin
                highTempStatus <= 1'b0;
            end
            lowVoltagePrev <= lowVoltageStatus;
            highTempPrev <= highTempStatus;
        end
    end

    // ==========================================================
    // Autonomous periodic timer
    wire apiTick = periodicClockSelect ? syncVal[SY_BUSRUN] : syncRise[SY_ACLK];
    wire apiExpire = periodicTimerEnable && apiTick && (apiCount == periodicRate);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            apiCount <= '0;
            periodicWave <= 1'b0;
        end else if (!periodicTimerEnable) begin
            apiCount <= '0;
            periodicWave <= 1'b0;
        end else if (apiExpire) begin
            apiCount <= '0;
            periodicWave <= !periodicWave;
        end else if (apiTick) begin
            apiCount <= apiCount + 16'h0001;
        end
    end

    // Pin is only driven while both enables are set; otherwise released
    always_ff @(posedge clk) begin
        if (!resetn) begin
            periodicWavePinOut <= 1'b0;
            periodicWavePinOe <= 1'b0;
        end else begin
            periodicWavePinOe <= periodicTimerEnable && periodicPinOutputEnable;
            periodicWavePinOut <= periodicTimerEnable && periodicPinOutputEnable
                                  && periodicWave;
        end
    end

    // ==========================================================
    // Event flags
    // A set in the same cycle as a clear wins, so no event is lost
    always_comb begin
        flagSet = '0;
        flagSet[FL_RTI] = rtiExpire;
        flagSet[FL_LOCK] = lockToggle;
        flagSet[FL_OSC] = oscQualified != oscQualPrev;
        flagSet[FL_LV] = lowVoltageStatus != lowVoltagePrev;
        flagSet[FL_HT] = highTempStatus != highTempPrev;
        flagSet[FL_API] = apiExpire;
    end

    wire [FL_W-1:0] flagClear = wrFlags ? regWdata[FL_W-1:0] : '0;

    always_comb begin
        next_flags = (flags & ~flagClear) | flagSet;
        flagEnable = '0;
        flagEnable[FL_RTI] = ctrl[CT_RTI_IE];
        flagEnable[FL_LOCK] = ctrl[CT_LOCK_IE];
        flagEnable[FL_OSC] = ctrl[CT_OSC_IE];
        flagEnable[FL_LV] = ctrl[CT_LV_IE];
        flagEnable[FL_HT] = ctrl[CT_HT_IE];
        flagEnable[FL_API] = periodicIrqEnable;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            flags <= '0;
            rtiIrq <= 1'b0;
            lockIrq <= 1'b0;
            oscIrq <= 1'b0;
            lowVoltageIrq <= 1'b0;
            highTempIrq <= 1'b0;
            periodicIrq <= 1'b0;
        end else begin
            flags <= next_flags;
            rtiIrq <= next_flags[FL_RTI] && ctrl[CT_RTI_IE];
            lockIrq <= next_flags[FL_LOCK] && ctrl[CT_LOCK_IE];
            oscIrq <= next_flags[FL_OSC] && ctrl[CT_OSC_IE];
            lowVoltageIrq <= next_flags[FL_LV] && ctrl[CT_LV_IE];
            highTempIrq <= next_flags[FL_HT] && ctrl[CT_HT_IE];
            periodicIrq <= next_flags[FL_API] && periodicIrqEnable;
        end
    end

    // ==========================================================
    // Read path
    logic [DATA_W-1:0] rdMux;

    always_comb begin
        rdMux = '0;
        unique case (regAddr)
            OFS_CTRL: rdMux[CT_W-1:0] = ctrl;
            OFS_FLAGS: begin
                rdMux[FL_W-1:0] = flags;
                rdMux[ST_LOCK] = lockNow;
                rdMux[ST_OSCQ] = oscQualified;
                rdMux[ST_LV] = lowVoltageStatus;
                rdMux[ST_HT] = highTempStatus;
            end
            OFS_RTI_RATE: rdMux = rtiRate;
            OFS_API_CTRL: begin
                rdMux[AP_EN] = periodicTimerEnable;
                rdMux[AP_CLKSEL] = periodicClockSelect;
                rdMux[AP_IE] = periodicIrqEnable;
                rdMux[AP_PINEN] = periodicPinOutputEnable;
                rdMux[AP_TRIM_LO +: TRIM_W] = autonomousClockTrim;
            end
            OFS_API_RATE: rdMux = periodicRate;
            OFS_WDOG: begin
                rdMux[WD_WIN] = watchdogWindowEnable;
                rdMux[WD_PER_LO +: WD_PER_W] = watchdogPeriodSelect;
                rdMux[WD_LOCKED] = watchdogLocked;
            end
            default: rdMux = '0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            regRdata <= '0;
        end else begin
            regRdata <= regRd ? rdMux : '0;
        end
    end

    // ==========================================================
    // Checks
    AST_RTI_RESTART:
    assert property (@(posedge clk) disable iff (!resetn)
        wrRtiRate |=> (rtiCount == '0))
        else $error("RTI count not restarted by rate write");

    AST_RTI_STOP_HOLD:
    assert property (@(posedge clk) disable iff (!resetn)
        (syncVal[SY_STOP] && !rtiStopRunEnable && !wrRtiRate) |=> $stable(rtiCount))
        else $error("RTI counted in stop without permission");

    AST_RTI_FLAG:
    assert property (@(posedge clk) disable iff (!resetn)
        rtiExpire |=> (flags[FL_RTI] && rtiCount == '0 && rtiIrq == $past(ctrl[CT_RTI_IE])))
        else $error("RTI expiry did not set flag or restart");

    AST_LOCK_FLAG:
    assert property (@(posedge clk) disable iff (!resetn)
        (syncVal[SY_LOCK] != syncPrev[SY_LOCK]) |=> flags[FL_LOCK])
        else $error("Lock toggle did not set flag");

    AST_LOCK_W1C:
    assert property (@(posedge clk) disable iff (!resetn)
        (wrFlags && !regWdata[FL_LOCK] && flags[FL_LOCK]) |=> flags[FL_LOCK])
        else $error("Writing zero cleared the lock flag");

    AST_OSCQ_NEEDS:
    assert property (@(posedge clk) disable iff (!resetn)
        oscQualified |-> $past(oscEnable) && $past(lockNow))
        else $error("Oscillator qualified without enable and lock");

    AST_OSCQ_LOSS:
    assert property (@(posedge clk) disable iff (!resetn)
        pllConfigChange |=> !oscQualified ##1 (!oscQualified || $past(syncRise[SY_LOCK])))
        else $error("Oscillator qualified survived a configuration change");

    AST_OSC_FLAG:
    assert property (@(posedge clk) disable iff (!resetn)
        $changed(oscQualified) |=> flags[FL_OSC])
        else $error("Qualified change did not set oscillator flag");

    AST_LV_FLAG:
    assert property (@(posedge clk) disable iff (!resetn)
        $changed(lowVoltageStatus) |=> flags[FL_LV])
        else $error("Low voltage change did not set flag");

    AST_API_LOCK:
    assert property (@(posedge clk) disable iff (!resetn)
        periodicTimerEnable |=> $stable(periodicRate) && $stable(periodicClockSelect))
        else $error("Periodic setup changed while timer enabled");

    AST_API_EXPIRE:
    assert property (@(posedge clk) disable iff (!resetn)
        apiExpire |=> (flags[FL_API] && apiCount == '0 && periodicIrq == $past(periodicIrqEnable)))
        else $error("Periodic expiry did not set flag or restart");

    AST_API_FREEZE:
    assert property (@(posedge clk) disable iff (!resetn)
        (periodicTimerEnable && periodicClockSelect && !syncVal[SY_BUSRUN])
        |=> $stable(apiCount))
        else $error("Periodic count moved with bus clock stopped");

    AST_IRQ_HOLD:
    assert property (@(posedge clk) disable iff (!resetn)
        (lockIrq && !wrFlags && !wrCtrl) |=> lockIrq)
        else $error("Lock request dropped without a clear");

endmodule
`default_nettype wire

// [bench/tb_clock_power_event_interrupts.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_clock_power_event_interrupts
    import cpei_pkg::*;
;
// ====
// Stimulus and observed signals
logic clk = 1'h0;
logic resetn = 1'h0;
logic regWr = 1'h0;
logic regRd = 1'h0;
logic [ADDR_W-1:0] regAddr = '0;
logic [DATA_W-1:0] regWdata = '0;
logic [DATA_W-1:0] q;
wire logic [DATA_W-1:0] regRdata;
logic [2:0] slow = '0;
logic busRun = 1'h0, stopM = 1'h0, fstop = 1'h0, full_performance_mode = 1'h0, lock = 1'h0, cfg = 1'h0;
logic [3:0] mon = '0;
wire logic [5:0] irqs;
wire logic waveOut, waveOe, wdWin;
wire logic [5:0] trim;
wire logic [2:0] wdPer;
int badCount = 0;
int checksDone = 0;
int cyc = 0;
always #10 clk = ~clk;
cpei_top dut (
    .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .internalRcClock(slow[0]), .oscillatorClock(slow[1]), .autonomousClock(slow[2]),
    .busClockRunning(busRun), .stopMode(stopM), .fullStopMode(fstop),
    .fullPerformanceMode(full_performance_mode), .pllLock(lock), .pllConfigChange(cfg),
    .lowVoltageBelowAssert(mon[0]), .lowVoltageAboveDeassert(mon[1]),
    .highTempAboveAssert(mon[2]), .highTempBelowDeassert(mon[3]),
    .rtiIrq(irqs[0]), .lockIrq(irqs[1]), .oscIrq(irqs[2]), .lowVoltageIrq(irqs[3]),
    .highTempIrq(irqs[4]), .periodicIrq(irqs[5]), .periodicWavePinOut(waveOut),
    .periodicWavePinOe(waveOe), .autonomousClockTrim(trim),
    .watchdogWindowEnable(wdWin), .watchdogPeriodSelect(wdPer)
);
// ====
// Bus and helper tasks
function automatic logic [15:0] b(input int i);
    return 16'h0001 << i;
endfunction
task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
    checksDone++;
    if (g !== e) begin
        badCount++;
        $display("mismatch %s expected %h seen %h", w, e, g);
    end
endtask
task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    regWr <= 1'h1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'h0;
endtask
task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'h0;
    #1 q = regRdata;
endtask
// Monitor inputs pass a synchroniser, so give them room
task automatic st();
    repeat (8) @(posedge clk);
endtask
task automatic cf(input string w, input logic [15:0] e);
    rd(OFS_FLAGS);
    chk(w, e, q);
endtask
// Ticks held 4 clk so the input filter never drops them
task automatic tk(input int i, input int n);
    repeat (n) begin
        @(posedge clk);
        slow[i] <= 1'h1;
        repeat (4) @(posedge clk);
        slow[i] <= 1'h0;
        repeat (4) @(posedge clk);
    end
    st();
endtask
task automatic rt(input int i, input int n, input logic e);
    tk(i, n);
    rd(OFS_FLAGS);
    chk("rti flag", {15'h0, e}, {15'h0, q[FL_RTI]});
    chk("rti irq", {15'h0, e}, {15'h0, irqs[0]});
    wr(OFS_FLAGS, b(FL_RTI));
endtask
// ====
// Scenarios
task automatic tReset();
    rd(OFS_CTRL);
    chk("ctrl", 16'h0000, q);
    cf("flags", 16'h0000);
    wr(4'hF, 16'hFFFF);
    rd(4'hF);
    chk("unmapped", 16'h0000, q);
    chk("irqs", 16'h0000, {10'h0, irqs});
    $display("test reset done");
endtask
task automatic tLock();
    wr(OFS_CTRL, b(CT_LOCK_IE));
    lock <= 1'h1;
    st();
    cf("lock set", b(ST_LOCK) | b(FL_LOCK));
    chk("lock irq", b(FL_LOCK), {10'h0, irqs});
    wr(OFS_FLAGS, 16'h0000);
    cf("lock w0", b(ST_LOCK) | b(FL_LOCK));
    wr(OFS_FLAGS, b(FL_LOCK));
    cf("lock w1", b(ST_LOCK));
    chk("lock irq off", 16'h0000, {10'h0, irqs});
    wr(OFS_CTRL, 16'h0000);
    lock <= 1'h0;
    st();
    cf("lock fall", b(FL_LOCK));
    chk("lock masked", 16'h0000, {10'h0, irqs});
    @(posedge clk) lock <= 1'h1;
    st();
    wr(OFS_FLAGS, 16'h003F);
    $display("test lock done");
endtask
task automatic tOsc();
    wr(OFS_CTRL, b(CT_OSC_EN) | b(CT_OSC_IE));
    st();
    cf("osc up", b(ST_LOCK) | b(ST_OSCQ) | b(FL_OSC));
    chk("osc irq", b(FL_OSC), {10'h0, irqs});
    wr(OFS_FLAGS, 16'h003F);
    cfg <= 1'h1;
    @(posedge clk) cfg <= 1'h0;
    st();
    cf("cfg change", b(ST_LOCK) | b(FL_OSC));
    @(posedge clk) lock <= 1'h0;
    st();
    @(posedge clk) lock <= 1'h1;
    st();
    wr(OFS_FLAGS, 16'h003F);
    cf("relock", b(ST_LOCK) | b(ST_OSCQ));
    @(posedge clk) fstop <= 1'h1;
    st();
    cf("full stop", b(ST_LOCK) | b(FL_OSC));
    @(posedge clk) fstop <= 1'h0;
    wr(OFS_CTRL, 16'h0000);
    st();
    wr(OFS_FLAGS, 16'h003F);
    cf("osc off", b(ST_LOCK));
    $display("test osc done");
endtask
task automatic tMon();
    int fl;
    int sb;
    for (int k = 0; k < 2; k++) begin
        fl = k ? FL_HT : FL_LV;
        sb = k ? ST_HT : ST_LV;
        wr(OFS_CTRL, b(k ? CT_HT_IE : CT_LV_IE));
        mon[2*k] <= 1'h1;
        st();
        cf("mon no fpm", b(ST_LOCK));
        @(posedge clk) full_performance_mode <= 1'h1;
        st();
        cf("mon assert", b(ST_LOCK) | b(sb) | b(fl));
        chk("mon irq", b(fl), {10'h0, irqs});
        wr(OFS_FLAGS, b(fl));
        mon[2*k] <= 1'h0;
        mon[2*k+1] <= 1'h1;
        st();
        cf("mon deassert", b(ST_LOCK) | b(fl));
        wr(OFS_FLAGS, b(fl));
        mon[2*k+1] <= 1'h0;
        full_performance_mode <= 1'h0;
    end
    $display("test monitors done");
endtask
task automatic tRti();
    wr(OFS_CTRL, b(CT_RTI_IE));
    wr(OFS_RTI_RATE, 16'h0002);
    rt(1, 3, 1'h0);
    rt(0, 2, 1'h0);
    rt(0, 1, 1'h1);
    rt(0, 2, 1'h0);
    rt(0, 1, 1'h1);
    rt(0, 2, 1'h0);
    wr(OFS_RTI_RATE, 16'h0002);
    rt(0, 2, 1'h0);
    rt(0, 1, 1'h1);
    stopM <= 1'h1;
    st();
    rt(0, 3, 1'h0);
    wr(OFS_CTRL, 16'h0017);
    rt(1, 3, 1'h1);
    stopM <= 1'h0;
    wr(OFS_CTRL, 16'h0000);
    $display("test rti done");
endtask
task automatic tApi();
    int n;
    logic w;
    busRun <= 1'h1;
    wr(OFS_API_RATE, 16'h0003);
    wr(OFS_API_CTRL, b(AP_CLKSEL));
    wr(OFS_API_CTRL, 16'h02AF);
    st();
    chk("api irq", 16'h0001, {15'h0, irqs[5]});
    chk("pin oe", 16'h0001, {15'h0, waveOe});
    chk("trim", 16'h002A, {10'h0, trim});
    n = 0;
    w = waveOut;
    repeat (40) begin
        @(posedge clk);
        #1 if (waveOut !== w) n++;
        w = waveOut;
    end
    chk("wave toggles", 16'h000A, 16'(n));
    wr(OFS_API_RATE, 16'h0007);
    rd(OFS_API_RATE);
    chk("rate locked", 16'h0003, q);
    wr(OFS_API_CTRL, 16'h02AD);
    rd(OFS_API_CTRL);
    chk("clksel locked", 16'h02AF, q);
    @(posedge clk) busRun <= 1'h0;
    st();
    wr(OFS_FLAGS, b(FL_API));
    w = waveOut;
    repeat (20) @(posedge clk);
    cf("frozen", b(ST_LOCK));
    chk("wave frozen", {15'h0, w}, {15'h0, waveOut});
    wr(OFS_API_CTRL, 16'h0000);
    wr(OFS_API_CTRL, 16'h0000);
    wr(OFS_API_RATE, 16'h0001);
    rd(OFS_API_RATE);
    chk("rate open", 16'h0001, q);
    chk("pin off", 16'h0000, {15'h0, waveOe});
    wr(OFS_FLAGS, b(FL_API));
    wr(OFS_API_CTRL, 16'h0005);
    tk(2, 1);
    cf("aclk one", b(ST_LOCK));
    tk(2, 1);
    cf("aclk two", b(ST_LOCK) | b(FL_API));
    wr(OFS_API_CTRL, 16'h0000);
    $display("test periodic done");
endtask
task automatic tWdog();
    wr(OFS_WDOG, 16'h000B);
    rd(OFS_WDOG);
    chk("wdog", 16'h010B, q);
    chk("wdog out", 16'h000B, {12'h0, wdPer, wdWin});
    wr(OFS_WDOG, 16'h0004);
    rd(OFS_WDOG);
    chk("wdog once", 16'h010B, q);
    $display("test watchdog done");
endtask
// ====
// Verdict and main sequence
task automatic endSim();
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0)
        $display("verification passed");
    else
        $display("verification failed");
    $finish;
endtask
always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
        badCount++;
        endSim();
    end
end
initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'h1;
    tReset();
    tLock();
    tOsc();
    tMon();
    tRti();
    tApi();
    tWdog();
    endSim();
end
endmodule
`default_nettype wire
